// File: logic/csr_dec.sv
// Decoder and executor for register add, extended pop and push, and return
`include "csr_dec_regs.svh"
module csr_dec #(
	parameter int SP_WIDTH = 12
) (
	input wire logic ref_clk,
	input wire logic rst,
	output csr_pkg::csr_pm_req_s pm_req,
	input wire logic [7:0] pm_rdata,
	output csr_pkg::csr_rf_req_s rf_req,
	input wire logic [7:0] rf_rdata,
	output logic [15:0] program_counter,
	output logic [11:0] stack_pointer,
	output logic [7:0] flags,
	output logic busy,
	output logic illegal
);
	// Stack pointer and register space are fixed at twelve bits
	if (SP_WIDTH != 12) begin : g_bad_width
		$error("csr_dec: SP_WIDTH must be 12");
	end

	csr_pkg::csr_state_e state;
	logic [7:0] opcode;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] lhs;
	logic [7:0] rhs;
	logic [7:0] ret_hi;
	logic [3:0] reg_page;
	logic [3:0] wr_page;
	logic [11:0] src_addr;
	logic [11:0] dst_addr;
	logic [11:0] ext_addr;
	logic src_esc;
	logic dst_esc;
	logic [7:0] sum;

	// Operand mapping for source and destination
	csr_addr_map u_src_map (
		.operand(b1),
		.reg_page(reg_page),
		.wr_page(wr_page),
		.full_addr(src_addr),
		.escaped(src_esc)
	);
	csr_addr_map u_dst_map (
		.operand(b2),
		.reg_page(reg_page),
		.wr_page(wr_page),
		.full_addr(dst_addr),
		.escaped(dst_esc)
	);

	// Operand count per opcode; unknown codes are refused
	function automatic logic [1:0] op_len(input logic [7:0] opc);
		case (opc)
			`CSR_OPC_ADD_RR: op_len = 2'd2;
			`CSR_OPC_POP_EXT: op_len = 2'd2;
			`CSR_OPC_PUSH_EXT: op_len = 2'd2;
			`CSR_OPC_RET: op_len = 2'd0;
			default: op_len = 2'd3;
		endcase
	endfunction

	// Extended 12-bit address spans bytes b1 and b2 high nibble
	assign ext_addr = {b1, b2[7:4]};
	assign sum = lhs + rhs;
	assign busy = (state != csr_pkg::CSR_FETCH_OP);
	assign illegal = (state == csr_pkg::CSR_HALT_BAD);

	// Fetch and register requests are combinational handshakes
	always_comb begin
		pm_req = '0;
		rf_req = '0;
		case (state)
			csr_pkg::CSR_FETCH_OP, csr_pkg::CSR_FETCH_B1, csr_pkg::CSR_FETCH_B2: begin
				pm_req.rd = 1'b1;
				pm_req.addr = program_counter;
			end
			csr_pkg::CSR_EXEC_RD1: begin
				rf_req.rd = 1'b1;
				if (opcode == `CSR_OPC_ADD_RR) begin
					rf_req.addr = src_addr;
				end else if (opcode == `CSR_OPC_POP_EXT) begin
					rf_req.addr = stack_pointer;
				end else begin
					rf_req.addr = ext_addr;
				end
			end
			csr_pkg::CSR_EXEC_RD2: begin
				rf_req.rd = 1'b1;
				rf_req.addr = dst_addr;
			end
			csr_pkg::CSR_EXEC_WR: begin
				rf_req.wr = 1'b1;
				if (opcode == `CSR_OPC_ADD_RR) begin
					rf_req.addr = dst_addr;
					rf_req.wdata = sum;
				end else if (opcode == `CSR_OPC_POP_EXT) begin
					rf_req.addr = ext_addr;
					rf_req.wdata = lhs;
				end else begin
					rf_req.addr = stack_pointer;
					rf_req.wdata = lhs;
				end
			end
			csr_pkg::CSR_RET_HI: begin
				rf_req.rd = 1'b1;
				rf_req.addr = stack_pointer;
			end
			csr_pkg::CSR_RET_LO: begin
				rf_req.rd = 1'b1;
				rf_req.addr = stack_pointer + `CSR_SP_STEP_ONE;
			end
			default: begin
			end
		endcase
	end

	// Sequencer; register file answers combinationally in the same cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= csr_pkg::CSR_FETCH_OP;
			opcode <= '0;
			b1 <= '0;
			b2 <= '0;
			lhs <= '0;
			rhs <= '0;
			ret_hi <= '0;
			reg_page <= `CSR_RP_RESET;
			wr_page <= `CSR_RP_RESET;
			program_counter <= `CSR_PC_RESET;
			stack_pointer <= `CSR_SP_RESET;
			flags <= '0;
		end else begin
			case (state)
				csr_pkg::CSR_FETCH_OP: begin
					opcode <= pm_rdata;
					program_counter <= program_counter + `CSR_PC_STEP;
					case (op_len(pm_rdata))
						2'd0: state <= csr_pkg::CSR_RET_HI;
						2'd2: state <= csr_pkg::CSR_FETCH_B1;
						default: state <= csr_pkg::CSR_HALT_BAD;
					endcase
				end
				csr_pkg::CSR_FETCH_B1: begin
					b1 <= pm_rdata;
					program_counter <= program_counter + `CSR_PC_STEP;
					state <= csr_pkg::CSR_FETCH_B2;
				end
				csr_pkg::CSR_FETCH_B2: begin
					b2 <= pm_rdata;
					program_counter <= program_counter + `CSR_PC_STEP;
					state <= csr_pkg::CSR_EXEC_RD1;
					if (opcode == `CSR_OPC_PUSH_EXT) begin
						stack_pointer <= stack_pointer - `CSR_SP_STEP_ONE;
					end
				end
				csr_pkg::CSR_EXEC_RD1: begin
					lhs <= rf_rdata;
					if (opcode == `CSR_OPC_ADD_RR) begin
						state <= csr_pkg::CSR_EXEC_RD2;
					end else begin
						state <= csr_pkg::CSR_EXEC_WR;
					end
				end
				csr_pkg::CSR_EXEC_RD2: begin
					rhs <= rf_rdata;
					state <= csr_pkg::CSR_EXEC_WR;
				end
				csr_pkg::CSR_EXEC_WR: begin
					// increment after the load, flags kept
					if (opcode == `CSR_OPC_POP_EXT) begin
						stack_pointer <= stack_pointer + `CSR_SP_STEP_ONE;
					end
					state <= csr_pkg::CSR_FETCH_OP;
				end
				csr_pkg::CSR_RET_HI: begin
					ret_hi <= rf_rdata;
					state <= csr_pkg::CSR_RET_LO;
				end
				csr_pkg::CSR_RET_LO: begin
					program_counter <= {ret_hi, rf_rdata};
					stack_pointer <= stack_pointer + `CSR_SP_STEP_RET;
					state <= csr_pkg::CSR_FETCH_OP;
				end
				csr_pkg::CSR_HALT_BAD: begin
					state <= csr_pkg::CSR_HALT_BAD;
				end
				default: state <= csr_pkg::CSR_FETCH_OP;
			endcase
		end
	end

	// Sum ends in destination register
	a_add_writes_dst: assert property (@(posedge ref_clk) disable iff (rst)
		(state == csr_pkg::CSR_EXEC_WR && opcode == `CSR_OPC_ADD_RR)
		|-> (rf_req.wr && rf_req.addr == dst_addr && rf_req.wdata == sum))
		else $error("add result not written to destination");
	a_src_fetch_first: assert property (@(posedge ref_clk) disable iff (rst)
		(state == csr_pkg::CSR_FETCH_B1) |=> (b1 == $past(pm_rdata)) && state == csr_pkg::CSR_FETCH_B2)
		else $error("source byte not taken first");
	a_absolute_reg: assert property (@(posedge ref_clk) disable iff (rst)
		!src_esc |-> src_addr[7:0] == b1)
		else $error("absolute operand mis-mapped");
	a_working_reg: assert property (@(posedge ref_clk) disable iff (rst)
		dst_esc |-> dst_addr == {wr_page, 4'h0, b2[3:0]})
		else $error("working register mis-mapped");
	sequence s_pop_wr;
		state == csr_pkg::CSR_EXEC_WR && opcode == `CSR_OPC_POP_EXT;
	endsequence
	a_pop_sp_inc: assert property (@(posedge ref_clk) disable iff (rst)
		s_pop_wr |=> stack_pointer == $past(stack_pointer) + `CSR_SP_STEP_ONE && $stable(flags))
		else $error("pop did not step stack pointer by one");
	a_push_sp_dec: assert property (@(posedge ref_clk) disable iff (rst)
		(state == csr_pkg::CSR_FETCH_B2 && opcode == `CSR_OPC_PUSH_EXT)
		|-> ##2 (rf_req.wr && rf_req.addr == $past(stack_pointer, 2) - `CSR_SP_STEP_ONE))
		else $error("push did not store at decremented stack");
	a_ret_sp_two: assert property (@(posedge ref_clk) disable iff (rst)
		(state == csr_pkg::CSR_RET_LO)
		|=> stack_pointer == $past(stack_pointer) + `CSR_SP_STEP_RET
		&& program_counter == {$past(ret_hi), $past(rf_rdata)})
		else $error("return did not reload pc or step stack");
	a_ret_len: assert property (@(posedge ref_clk) disable iff (rst)
		(state == csr_pkg::CSR_FETCH_OP && pm_rdata == `CSR_OPC_RET)
		|=> state == csr_pkg::CSR_RET_HI ##1 state == csr_pkg::CSR_RET_LO
		##1 state == csr_pkg::CSR_FETCH_OP)
		else $error("return sequence wrong length");
endmodule

// File: logic/csr_dec_regs.svh
// Opcode encodings, operand layout and machine constants for the decoder
`ifndef CSR_DEC_REGS_SVH
`define CSR_DEC_REGS_SVH
`define CSR_OPC_ADD_RR 8'h04
`define CSR_OPC_POP_EXT 8'hD8
`define CSR_OPC_PUSH_EXT 8'hC8
`define CSR_OPC_RET 8'hAF
`define CSR_ESC_NIBBLE 4'hE
`define CSR_RP_RESET 4'h0
`define CSR_SP_RESET 12'h000
`define CSR_PC_RESET 16'h0000
`define CSR_SP_STEP_ONE 12'h001
`define CSR_SP_STEP_RET 12'h002
`define CSR_PC_STEP 16'h0001
`define CSR_SP_HI_ADDR 12'hFFE
`define CSR_SP_LO_ADDR 12'hFFF
`endif

// File: logic/csr_pkg.sv
// Types shared by the stack, return and operand decoder
package csr_pkg;
	typedef enum logic [3:0] {
		CSR_FETCH_OP,
		CSR_FETCH_B1,
		CSR_FETCH_B2,
		CSR_FETCH_B3,
		CSR_EXEC_RD1,
		CSR_EXEC_RD2,
		CSR_EXEC_WR,
		CSR_RET_HI,
		CSR_RET_LO,
		CSR_HALT_BAD
	} csr_state_e;
	// Register file access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} csr_rf_req_s;
	// Program memory fetch request
	typedef struct packed {
		logic rd;
		logic [15:0] addr;
	} csr_pm_req_s;
endpackage

// File: logic/csr_addr_map.sv
// Maps an 8-bit register operand onto the 12-bit register space
`include "csr_dec_regs.svh"
module csr_addr_map (
	input wire logic [7:0] operand,
	input wire logic [3:0] reg_page,
	input wire logic [3:0] wr_page,
	output logic [11:0] full_addr,
	output logic escaped
);
	// Escaped form picks a working register, else absolute 0 to 255
	// working register select
	assign escaped = (operand[7:4] == `CSR_ESC_NIBBLE);
	assign full_addr = escaped ? {wr_page, 4'h0, operand[3:0]} : {reg_page, operand};
endmodule

// File: testbench/csr_mem_model.sv
// Program memory and register file model facing the decoder
module csr_mem_model (
	input wire logic ref_clk,
	input wire csr_pkg::csr_pm_req_s pm_req,
	output logic [7:0] pm_rdata,
	input wire csr_pkg::csr_rf_req_s rf_req,
	output logic [7:0] rf_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] pm [0:65535];
	logic [7:0] rf [0:4095];
	logic [7:0] junk = 8'h3C;
	// Write on the pulse; junk changes every cycle so stale reads show
	always @(posedge ref_clk) begin
		junk <= junk + 8'h5B;
		if (rf_req.wr) begin
			rf[rf_req.addr] <= rf_req.wdata;
		end
	end
	// Same-cycle reads; unselected reads give garbage, not old data
	assign pm_rdata = pm_req.rd ? pm[pm_req.addr] : junk;
	assign rf_rdata = rf_req.rd ? rf[rf_req.addr] : ~junk;
endmodule

// File: testbench/cpu_stack_return_operand_decode_tb.sv
// Random and corner-case bench for the stack, return and operand decoder
module cpu_stack_return_operand_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	csr_pkg::csr_pm_req_s pm_req;
	csr_pkg::csr_rf_req_s rf_req;
	logic [7:0] pm_rdata;
	logic [7:0] rf_rdata;
	logic [7:0] flags;
	logic [15:0] program_counter;
	logic [11:0] stack_pointer;
	logic busy;
	logic illegal;
	int failures = 0;
	int n_checks = 0;
	logic [7:0] src [0:8];
	logic [7:0] dst [0:8];
	logic [7:0] va [0:8];
	logic [7:0] vb [0:8];
	logic used [0:255] = '{default: 1'b0};
	logic [15:0] pa;
	logic [15:0] ret_pc;
	logic [11:0] ea;
	logic [11:0] eb;
	logic [7:0] pv;
	logic [7:0] x;
	logic [7:0] lo;

	// Free-running 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	csr_dec #(.SP_WIDTH(12)) dut_u (.ref_clk(ref_clk), .rst(rst), .pm_req(pm_req),
		.pm_rdata(pm_rdata), .rf_req(rf_req), .rf_rdata(rf_rdata),
		.program_counter(program_counter), .stack_pointer(stack_pointer),
		.flags(flags), .busy(busy), .illegal(illegal));

	csr_mem_model mem_u (.ref_clk(ref_clk), .pm_req(pm_req), .pm_rdata(pm_rdata),
		.rf_req(rf_req), .rf_rdata(rf_rdata));

	// Escaped operands land in the working registers of page zero
	function automatic logic [11:0] rf_addr(input logic [7:0] op);
		return (op[7:4] == 4'hE) ? {8'h00, op[3:0]} : {4'h0, op};
	endfunction

	// Unique plain register, clear of the working and stack bytes
	function automatic logic [7:0] pick();
		logic [7:0] r;
		r = 8'h10 + 8'($urandom % 208);
		while (used[r]) r = (r == 8'hDF) ? 8'h10 : r + 8'h01;
		used[r] = 1'b1;
		return r;
	endfunction

	task automatic put(input logic [7:0] b);
		mem_u.pm[pa] = b;
		pa = pa + 16'h0001;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bounded wait for the opcode fetch at the given address
	task automatic wait_pc(input logic [15:0] target);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (!(program_counter === target && busy === 1'b0) && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		chk(program_counter, target);
	endtask

	task automatic results();
		if (failures == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Hang guard, far beyond the fewer than a hundred cycles of the program
	initial begin
		#50us;
		failures++;
		results();
	end

	// Build program and data, release reset, then follow each instruction
	initial begin
		void'($urandom(76606));
		pa = 16'h0000;
		for (int i = 0; i < 9; i++) begin
			src[i] = (i == 8) ? 8'hE8 : pick();
			dst[i] = (i == 7) ? 8'hE3 : pick();
			va[i] = 8'($urandom);
			vb[i] = 8'($urandom);
			mem_u.rf[rf_addr(src[i])] = va[i];
			mem_u.rf[rf_addr(dst[i])] = vb[i];
			put(8'h04);
			put(src[i]);
			put(dst[i]);
		end
		// Boundary registers FF and 00; the sum becomes the return high byte
		x = 8'($urandom % 128);
		mem_u.rf[12'h0FF] = x;
		mem_u.rf[12'h000] = 8'h40;
		put(8'h04);
		put(8'hFF);
		put(8'h00);
		ea = 12'h100 + 12'($urandom % 1792);
		eb = ea + 12'h800;
		pv = 8'($urandom);
		mem_u.rf[ea] = pv;
		put(8'hC8);
		put(ea[11:4]);
		put({ea[3:0], 4'h5});
		put(8'hD8);
		put(eb[11:4]);
		put({eb[3:0], 4'hA});
		put(8'hAF);
		lo = 8'($urandom);
		mem_u.rf[12'h001] = lo;
		ret_pc = {x + 8'h40, lo};
		mem_u.pm[ret_pc] = 8'h00;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			wait_pc(16'(3 * i + 3));
			chk(mem_u.rf[rf_addr(dst[i])], 8'(va[i] + vb[i]));
			chk(mem_u.rf[rf_addr(src[i])], va[i]);
		end
		wait_pc(16'd30);
		chk(mem_u.rf[12'h000], x + 8'h40);
		wait_pc(16'd33);
		chk(stack_pointer, 12'hFFF);
		chk(mem_u.rf[12'hFFF], pv);
		wait_pc(16'd36);
		chk(stack_pointer, 12'h000);
		chk(mem_u.rf[eb], pv);
		wait_pc(ret_pc);
		chk(stack_pointer, 12'h002);
		chk(flags, 8'h00);
		repeat (3) @(negedge ref_clk);
		chk(illegal, 1'b1);
		results();
	end
endmodule
